// ===== rtl/smtp_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef SMTP_CONSTS_SVH
`define SMTP_CONSTS_SVH
`define SMTP_CTRL_ADDR 8'h09
`define SMTP_TAP_LSB 0
`define SMTP_TAP_MSB 2
`define SMTP_BON_BIT 3
`define SMTP_BLF_BIT 5
`define SMTP_CTRL_RST 8'h00
`define SMTP_CLK_PERIOD_NS 4
`define SMTP_LVR_TIME_NS 1000000
`define SMTP_LVR_CYCLES ((`SMTP_LVR_TIME_NS + `SMTP_CLK_PERIOD_NS - 1) / `SMTP_CLK_PERIOD_NS)
`define SMTP_BON_WAIT_NS 1000000
`define SMTP_BZ_SEL_RST 0
`define SMTP_TAP_BASE 4
`endif

// ===== rtl/smtp_lvr_filter.sv
// supply-drop filter: fires only on a low supply held past the limit
`timescale 1ns/10ps
`default_nettype none
`include "smtp_consts.svh"
module smtp_lvr_filter #(
   parameter int unsigned LVR_CYCLES = `SMTP_LVR_CYCLES
) (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // supply sense
   input wire logic arm_i,
   input wire logic low_i,
   output logic fire_o
);
   localparam int unsigned CW = $clog2(LVR_CYCLES + 1);
   smtp_pkg::smtp_lvr_state_t state;
   logic [CW-1:0] cnt;

   // =====================================================
   // filter state
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= smtp_pkg::SMTP_LVR_IDLE;
      end else if (ce_i) begin
         if (!arm_i || !low_i) begin
            state <= smtp_pkg::SMTP_LVR_IDLE;
         end else begin
            unique case (state)
               smtp_pkg::SMTP_LVR_IDLE: state <= smtp_pkg::SMTP_LVR_COUNT;
               smtp_pkg::SMTP_LVR_COUNT: begin
                  if (cnt == CW'(LVR_CYCLES)) begin
                     state <= smtp_pkg::SMTP_LVR_FIRE;
                  end
               end
               smtp_pkg::SMTP_LVR_FIRE: state <= smtp_pkg::SMTP_LVR_FIRE;
               default: state <= smtp_pkg::SMTP_LVR_IDLE;
            endcase
         end
      end
   end

   // low samples seen so far
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (ce_i) begin
         if (!arm_i || !low_i) begin
            cnt <= '0;
         end else if (state != smtp_pkg::SMTP_LVR_FIRE) begin
            cnt <= cnt + CW'(1);
         end
      end
   end

   assign fire_o = (state == smtp_pkg::SMTP_LVR_FIRE);

   // =====================================================
   // checks
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   fire_needs_hold_a: assert property ($rose(fire_o) |-> $past(cnt) == CW'(LVR_CYCLES))
      else $error("supply-drop reset fired before the hold time");
   halt_blocks_fire_a: assert property (ce_i && !arm_i |=> !fire_o)
      else $error("supply-drop reset active while disarmed");
endmodule
`default_nettype wire

// ===== rtl/smtp_pkg.sv
// types shared by the supply monitor and tone pin block
package smtp_pkg;
   typedef enum logic [1:0] {
      SMTP_SUP_BOTH = 2'b00,
      SMTP_SUP_NONE = 2'b01,
      SMTP_SUP_DET_ONLY = 2'b10
   } smtp_supply_opt_t;
   typedef enum logic [1:0] {
      SMTP_LVR_IDLE = 2'b00,
      SMTP_LVR_COUNT = 2'b01,
      SMTP_LVR_FIRE = 2'b10
   } smtp_lvr_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } smtp_reg_req_t;
endpackage

// ===== rtl/smtp_supply_tone.sv
// supply monitor, reset combiner and tone pin top
`timescale 1ns/10ps
`default_nettype none
`include "smtp_consts.svh"
module smtp_supply_tone #(
   parameter logic BUZZER_ON = 1'b1,
   parameter logic PFD_ON = 1'b1,
   parameter smtp_pkg::smtp_supply_opt_t SUPPLY_OPT = smtp_pkg::SMTP_SUP_BOTH,
   parameter int unsigned BZ_SEL = `SMTP_BZ_SEL_RST,
   parameter int unsigned TAP_BASE = `SMTP_TAP_BASE,
   parameter int unsigned LVR_CYCLES = `SMTP_LVR_CYCLES
) (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // data memory access
   input wire smtp_pkg::smtp_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // analog sense and chip state
   input wire logic batt_low_i,
   input wire logic supply_low_i,
   input wire logic halt_i,
   input wire logic external_reset_n_i,
   // timing sources
   input wire logic fs_tick_i,
   input wire logic timer_ovf_i,
   // port a output latches
   input wire logic port_a_bit0_latch_i,
   input wire logic port_a_bit1_latch_i,
   input wire logic port_a_bit3_latch_i,
   // pins and status
   output logic port_a_bit0_o,
   output logic port_a_bit1_o,
   output logic port_a_bit3_o,
   output logic chip_reset_o,
   output logic rtc_tap_o,
   output logic low_volt_detect_on_o,
   output logic battery_low_flag_o
);
   // =====================================================
   // build options
   localparam logic DET_ALLOWED = (SUPPLY_OPT != smtp_pkg::SMTP_SUP_NONE);
   localparam logic LVR_ALLOWED = (SUPPLY_OPT == smtp_pkg::SMTP_SUP_BOTH);

   logic [2:0] prescaler_tap_sel;
   logic low_volt_detect_on;
   logic battery_low_flag;
   logic freq_divider_out;
   logic buzzer_tone_out;
   logic tap_w;
   logic lvr_fire;
   logic det_active;
   logic ctrl_hit;
   logic next_bit0;
   logic next_bit1;
   logic next_bit3;

   localparam logic [7:0] CTRL_RST = `SMTP_CTRL_RST;

   assign ctrl_hit = (reg_req_i.addr == `SMTP_CTRL_ADDR);
   assign det_active = DET_ALLOWED && low_volt_detect_on;

   // =====================================================
   // control register writable fields
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         prescaler_tap_sel <= CTRL_RST[`SMTP_TAP_MSB:`SMTP_TAP_LSB];
         low_volt_detect_on <= CTRL_RST[`SMTP_BON_BIT];
      end else if (ce_i && reg_req_i.wr && ctrl_hit) begin
         prescaler_tap_sel <= reg_req_i.wdata[`SMTP_TAP_MSB:`SMTP_TAP_LSB];
         low_volt_detect_on <= reg_req_i.wdata[`SMTP_BON_BIT];
      end
   end

   // =====================================================
   // battery low flag, forced low while detector off
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         battery_low_flag <= 1'b0;
      end else if (ce_i) begin
         battery_low_flag <= det_active && batt_low_i;
      end
   end

   // =====================================================
   // register read port, unused bits read zero
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_req_i.rd) begin
         if (ctrl_hit) begin
            reg_rdata_o <= 8'h00;
            reg_rdata_o[`SMTP_TAP_MSB:`SMTP_TAP_LSB] <= prescaler_tap_sel;
            reg_rdata_o[`SMTP_BON_BIT] <= low_volt_detect_on;
            reg_rdata_o[`SMTP_BLF_BIT] <= battery_low_flag;
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // =====================================================
   // tone divider and prescaler taps
   smtp_tone_div #(
      .BZ_SEL(BZ_SEL),
      .TAP_BASE(TAP_BASE)
   ) u_tone (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .fs_tick_i(fs_tick_i),
      .tap_sel_i(prescaler_tap_sel),
      .tone_o(buzzer_tone_out),
      .tap_o(tap_w)
   );

   // =====================================================
   // divider output, half the timer overflow rate
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         freq_divider_out <= 1'b0;
      end else if (ce_i && timer_ovf_i) begin
         freq_divider_out <= !freq_divider_out;
      end
   end

   // =====================================================
   // pin selection
   always_comb begin
      if (BUZZER_ON) begin
         next_bit0 = !port_a_bit0_latch_i && buzzer_tone_out;
         next_bit1 = !port_a_bit0_latch_i && !port_a_bit1_latch_i
            && !buzzer_tone_out;
      end else begin
         next_bit0 = port_a_bit0_latch_i;
         next_bit1 = port_a_bit1_latch_i;
      end
      if (PFD_ON) begin
         next_bit3 = !port_a_bit3_latch_i && freq_divider_out;
      end else begin
         next_bit3 = port_a_bit3_latch_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         port_a_bit0_o <= 1'b0;
         port_a_bit1_o <= 1'b0;
         port_a_bit3_o <= 1'b0;
      end else if (ce_i) begin
         port_a_bit0_o <= next_bit0;
         port_a_bit1_o <= next_bit1;
         port_a_bit3_o <= next_bit3;
      end
   end

   // =====================================================
   // supply-drop filter and reset combiner
   smtp_lvr_filter #(
      .LVR_CYCLES(LVR_CYCLES)
   ) u_lvr (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .arm_i(LVR_ALLOWED && !halt_i),
      .low_i(supply_low_i),
      .fire_o(lvr_fire)
   );

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         chip_reset_o <= 1'b0;
      end else if (ce_i) begin
         chip_reset_o <= lvr_fire || !external_reset_n_i;
      end
   end

   // =====================================================
   // status outputs
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rtc_tap_o <= 1'b0;
         low_volt_detect_on_o <= 1'b0;
         battery_low_flag_o <= 1'b0;
      end else if (ce_i) begin
         rtc_tap_o <= tap_w;
         low_volt_detect_on_o <= det_active;
         battery_low_flag_o <= battery_low_flag;
      end
   end

   // =====================================================
   // checks
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence ctrl_wr_s;
      ce_i && reg_req_i.wr && ctrl_hit;
   endsequence

   sequence ctrl_rd_s;
      ce_i && reg_req_i.rd && !reg_req_i.wr && ctrl_hit;
   endsequence

   blf_sets_low_a: assert property (ce_i && det_active && batt_low_i |=> battery_low_flag)
      else $error("battery low flag not set");
   bon_write_a: assert property (ctrl_wr_s |=> low_volt_detect_on == $past(reg_req_i.wdata[3]))
      else $error("detector enable did not follow write");
   blf_off_zero_a: assert property (ce_i && !det_active |=> !battery_low_flag)
      else $error("battery low flag set with detector off");
   buzz_pair_a: assert property (ce_i && BUZZER_ON && !port_a_bit0_latch_i
      && !port_a_bit1_latch_i |=> port_a_bit0_o == $past(buzzer_tone_out)
      && port_a_bit1_o == !port_a_bit0_o)
      else $error("buzzer pins not a complementary pair");
   buzz_single_a: assert property (ce_i && BUZZER_ON && !port_a_bit0_latch_i
      && port_a_bit1_latch_i |=> port_a_bit0_o == $past(buzzer_tone_out)
      && !port_a_bit1_o)
      else $error("single buzzer output wrong");
   buzz_stop_a: assert property (ce_i && BUZZER_ON && port_a_bit0_latch_i
      |=> !port_a_bit0_o && !port_a_bit1_o)
      else $error("buzzer pins not low while stopped");
   pfd_route_a: assert property (ce_i && PFD_ON |=> port_a_bit3_o ==
      (!$past(port_a_bit3_latch_i) && $past(freq_divider_out)))
      else $error("divider pin routing wrong");
   pfd_toggle_a: assert property (ce_i && timer_ovf_i |=> freq_divider_out != $past(freq_divider_out))
      else $error("divider output missed an overflow");
   ext_reset_a: assert property (ce_i && !external_reset_n_i |=> chip_reset_o)
      else $error("external reset not passed to chip reset");
   halt_quiet_a: assert property (ce_i && halt_i |=> !lvr_fire)
      else $error("supply-drop reset active in halt");
   tap_readback_a: assert property (ctrl_wr_s ##1 ctrl_rd_s |=>
      reg_rdata_o[2:0] == $past(reg_req_i.wdata[2:0], 2))
      else $error("tap select readback mismatch");
   opt_no_lvr_a: assert property (!LVR_ALLOWED |-> !lvr_fire)
      else $error("supply-drop reset fired while excluded");
   unused_bits_a: assert property (reg_rdata_o[4] == 1'b0 && reg_rdata_o[7:6] == 2'b00)
      else $error("unused read bits not zero");
endmodule
`default_nettype wire

// ===== rtl/smtp_tone_div.sv
// buzzer tone divider and clock prescaler tap mux
`timescale 1ns/10ps
`default_nettype none
`include "smtp_consts.svh"
module smtp_tone_div #(
   parameter int unsigned BZ_SEL = `SMTP_BZ_SEL_RST,
   parameter int unsigned TAP_BASE = `SMTP_TAP_BASE
) (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // system clock tick and tap select
   input wire logic fs_tick_i,
   input wire logic [2:0] tap_sel_i,
   // divided outputs
   output logic tone_o,
   output logic tap_o
);
   localparam int unsigned PW = TAP_BASE + 8;
   logic [PW-1:0] cnt;
   logic [7:0] taps;

   // =====================================================
   // prescaler counter, one step per system clock tick
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (ce_i && fs_tick_i) begin
         cnt <= cnt + PW'(1);
      end
   end

   // bit k has a period of 2^(k+1) ticks
   assign tone_o = cnt[BZ_SEL + 1];
   assign taps = cnt[TAP_BASE +: 8];
   assign tap_o = taps[tap_sel_i];
endmodule
`default_nettype wire

// ===== testbench/smtp_supply_tone_test.sv
// self-checking bench for the supply monitor and tone pin block
`timescale 1ns/10ps
`default_nettype none
`include "smtp_consts.svh"
module smtp_supply_tone_test;
   localparam int BZ = 0;
   localparam int TB = 4;
   localparam int LC = 8;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   smtp_pkg::smtp_reg_req_t req = '0;
   logic [7:0] rdata;
   logic batt = 1'b0, sup = 1'b0, halt = 1'b0, ext_n = 1'b1, ovf = 1'b0;
   logic l0 = 1'b1, l1 = 1'b1, l3 = 1'b1;
   logic p0, p1, p3, crst, tap, bon_o, flag_o;
   logic [31:0] seed = 32'h28C7;
   int error_cnt = 0;
   int checked = 0;
   int t0, t1, t3, tt, same, hi1, hi3;
   always #2 ref_clk_i = ~ref_clk_i;
   smtp_supply_tone #(.BZ_SEL(BZ), .TAP_BASE(TB), .LVR_CYCLES(LC)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_req_i(req),
      .reg_rdata_o(rdata), .batt_low_i(batt), .supply_low_i(sup), .halt_i(halt),
      .external_reset_n_i(ext_n), .fs_tick_i(1'b1), .timer_ovf_i(ovf),
      .port_a_bit0_latch_i(l0), .port_a_bit1_latch_i(l1), .port_a_bit3_latch_i(l3),
      .port_a_bit0_o(p0), .port_a_bit1_o(p1), .port_a_bit3_o(p3), .chip_reset_o(crst),
      .rtc_tap_o(tap), .low_volt_detect_on_o(bon_o), .battery_low_flag_o(flag_o));
   // =========================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // changes expected on a counter bit over n cycles
   function automatic int flips(input int n, input int bit_idx);
      return n >> bit_idx;
   endfunction
   function automatic logic near(input int got, input int exp);
      return (got >= exp - 1) && (got <= exp + 1);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge ref_clk_i);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge ref_clk_i);
      req <= '0;
      cyc(1);
      d = rdata;
   endtask
   // write then read on the very next edge
   task automatic wrrd(input logic [7:0] d_w, output logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{addr: `SMTP_CTRL_ADDR, wr: 1'b1, rd: 1'b0, wdata: d_w};
      @(posedge ref_clk_i);
      req <= '{addr: `SMTP_CTRL_ADDR, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge ref_clk_i);
      req <= '0;
      cyc(1);
      d = rdata;
   endtask
   // count output changes over n cycles
   task automatic watch(input int n);
      logic q0, q1, q3, qt;
      t0 = 0; t1 = 0; t3 = 0; tt = 0; same = 0; hi1 = 0; hi3 = 0;
      q0 = p0; q1 = p1; q3 = p3; qt = tap;
      repeat (n) begin
         cyc(1);
         t0 += (p0 !== q0); t1 += (p1 !== q1); t3 += (p3 !== q3); tt += (tap !== qt);
         same += (p0 === p1); hi1 += (p1 === 1'b1); hi3 += (p3 === 1'b1);
         q0 = p0; q1 = p1; q3 = p3; qt = tap;
      end
   endtask
   task automatic lvr_run(input int n, input logic h, input logic exp_fire);
      int hits;
      hits = 0;
      @(posedge ref_clk_i);
      sup <= 1'b1;
      halt <= h;
      repeat (n) @(posedge ref_clk_i);
      sup <= 1'b0;
      repeat (6) begin
         cyc(1);
         hits += (crst === 1'b1);
      end
      chk(hits != 0, exp_fire);
      halt <= 1'b0;
      cyc(4);
   endtask
   initial begin
      repeat (50000) @(posedge ref_clk_i);
      error_cnt++;
      summarize();
   end
   // =========================================
   // main sequence
   initial begin
      logic [7:0] d, v;
      int k;
      cyc(2);
      rst_i <= 1'b0;
      rd(`SMTP_CTRL_ADDR, d);
      chk(d, `SMTP_CTRL_RST);
      repeat (8) begin
         seed = xs(seed);
         v = seed[7:0];
         batt <= seed[8];
         wr(`SMTP_CTRL_ADDR, v);
         rd(`SMTP_CTRL_ADDR, d);
         chk(d, {2'b00, v[3] & seed[8], 1'b0, v[3:0]});
         chk(bon_o, v[3]);
         chk(flag_o, v[3] & seed[8]);
      end
      seed = xs(seed);
      wrrd({5'h00, seed[2:0]}, d);
      chk(d[2:0], seed[2:0]);
      wr(`SMTP_CTRL_ADDR, 8'h08);
      wr(seed[7:0] | 8'h10, 8'hFF);
      rd(`SMTP_CTRL_ADDR, d);
      chk(d[3:0], 4'h8);
      rd(seed[7:0] | 8'h10, d);
      chk(d, 8'h00);
      $display("register test done");
      for (k = 0; k < 3; k++) begin
         wr(`SMTP_CTRL_ADDR, k[7:0]);
         watch(128);
         chk(near(tt, flips(128, TB + k)), 1'b1);
      end
      $display("tap test done");
      for (k = 0; k < 4; k++) begin
         seed = xs(seed);
         @(posedge ref_clk_i);
         l0 <= k[1];
         l1 <= (k == 3) ? seed[0] : k[0];
         cyc(3);
         watch(128);
         if (k == 0) begin
            chk(same, 0);
            chk(near(t0, flips(128, BZ + 1)), 1'b1);
         end else if (k == 1) begin
            chk(hi1, 0);
            chk(near(t0, flips(128, BZ + 1)), 1'b1);
         end else begin
            chk({t0 != 0, t1 != 0, p0, p1}, 4'h0);
         end
      end
      $display("buzzer test done");
      @(posedge ref_clk_i);
      l3 <= 1'b1;
      ovf <= 1'b1;
      @(posedge ref_clk_i);
      ovf <= 1'b0;
      cyc(3);
      watch(16);
      chk({t3 != 0, hi3 != 0}, 2'b00);
      @(posedge ref_clk_i);
      l3 <= 1'b0;
      cyc(3);
      for (k = 0; k < 4; k++) begin
         v[0] = p3;
         @(posedge ref_clk_i);
         ovf <= 1'b1;
         @(posedge ref_clk_i);
         ovf <= 1'b0;
         cyc(4);
         chk(p3, !v[0]);
      end
      $display("divider test done");
      lvr_run(LC, 1'b0, 1'b0);
      lvr_run(LC + 12, 1'b1, 1'b0);
      lvr_run(LC + 12, 1'b0, 1'b1);
      $display("supply reset test done");
      @(posedge ref_clk_i);
      ext_n <= 1'b0;
      @(posedge ref_clk_i);
      ext_n <= 1'b1;
      #1;
      chk(crst, 1'b1);
      cyc(1);
      chk(crst, 1'b0);
      $display("external reset test done");
      summarize();
   end
endmodule
`default_nettype wire
